// *** include/audio_out_cfg.svh ***
// Offsets, reset values, write masks, buffer sizes and counter widths of the audio output block.
// Assumes inclusion by bare name from the package and the core.
`ifndef AUDIO_OUT_CFG_SVH
`define AUDIO_OUT_CFG_SVH
`define AO_OFS_FORMAT    8'h9a
`define AO_OFS_SOURCE    8'h9b
`define AO_OFS_STATUS    8'h9c
`define AO_OFS_SAMPLE    8'h9d
`define AO_OFS_DIVISOR   8'hec
`define AO_RST_FORMAT    8'h08
`define AO_RST_SOURCE    8'hb2
`define AO_RST_STATUS    8'hc0
`define AO_RST_SAMPLE    8'hff
`define AO_RST_DIVISOR   8'h00
`define AO_SRC_WMASK     8'hf7
`define AO_DIV_WMASK     8'h1f
`define AO_BUF_DEPTH     4'h8
`define AO_BUF_HALF      4'h4
`define AO_CNT_W         4
`define AO_PTR_W         3
`endif

// *** include/audio_out_pkg.sv ***
// Types of the audio output control block.
// Assumes audio_out_cfg.svh on the include path.
`include "audio_out_cfg.svh"
package audio_out_pkg;
   typedef struct packed {
      logic [4:0] justify;
      logic       ws_polarity;
      logic       slot_size;
      logic       clk_ratio;
   } format_t;
   typedef struct packed {
      logic       src_cpu;
      logic       dec_fetch_en;
      logic       sample_request_flag_mask;
      logic       underrun_flag_mask;
      logic       resv;
      logic [1:0] repeat_factor;
      logic       if_enable;
   } source_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sfr_req_t;
   typedef enum logic [1:0] {
      ST_OFF,
      ST_RUN
   } play_t;
   typedef struct packed {
      format_t                 fmt;
      source_t                 src;
      logic [4:0]              div;
      logic [7:0]              sample;
      logic                    sample_request_flag;
      logic                    underrun_flag;
      logic [`AO_CNT_W-1:0]    count;
      logic [`AO_PTR_W-1:0]    rd_ptr;
      logic [`AO_PTR_W-1:0]    wr_ptr;
      logic [2:0]              rep_cnt;
      logic [7:0]              rdata;
      logic [15:0]             skid0;
      logic [15:0]             skid1;
      logic [1:0]              skid_n;
      play_t                   play;
   } state_t;
endpackage : audio_out_pkg

// *** core/audio_out_ctrl.sv ***
// Control, status and voice buffer of the audio serial output.
// Assumes an 8-bit SFR port on clock; serializer downstream takes 16-bit words
// with valid/ready; decoder words arrive on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "audio_out_cfg.svh"
module audio_out_ctrl (
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire audio_out_pkg::sfr_req_t  sfr,
   output logic [7:0]                    sfr_rdata,
   input  wire logic                     irq_global_en,
   output logic                          audio_irq,
   input  wire logic [15:0]              dec_data,
   input  wire logic                     dec_valid,
   output logic                          dec_request,
   output logic [15:0]                   ser_data,
   output logic                          ser_valid,
   input  wire logic                     ser_ready,
   output audio_out_pkg::format_t        ser_format,
   output logic                          if_enabled,
   output logic [4:0]                    clk_divisor
);
   audio_out_pkg::state_t  s_ff;
   audio_out_pkg::state_t  nxt_s;
   logic [7:0]             mem_ff [0:7];
   logic [7:0]             status;
   logic                   wr_sample;
   logic                   pop;
   logic                   skid_ready;
   logic                   cpu_valid;
   logic [15:0]            in_word;
   logic                   in_valid;
   logic [2:0]             rep_max;

   ////////////////////////////////////////////////////////////////////////////
   assign status    = {s_ff.sample_request_flag, s_ff.underrun_flag, (s_ff.count == `AO_BUF_DEPTH), 5'h00};
   assign wr_sample = sfr.wr && (sfr.addr == `AO_OFS_SAMPLE) && (s_ff.count != `AO_BUF_DEPTH);
   assign skid_ready = (s_ff.skid_n != 2'h2);
   assign cpu_valid = s_ff.src.src_cpu && s_ff.src.if_enable && (s_ff.count != 4'h0);
   // Repeat count per sample: 1, 2, 4 or 6 words
   always_comb begin
      case (s_ff.src.repeat_factor)
         2'h0:    rep_max = 3'h0;
         2'h1:    rep_max = 3'h1;
         2'h2:    rep_max = 3'h3;
         default: rep_max = 3'h5;
      endcase
   end
   always_comb begin
      if (s_ff.src.src_cpu) begin
         in_word  = {mem_ff[s_ff.rd_ptr], 8'h00};
         in_valid = cpu_valid;
      end else begin
         in_word  = dec_data;
         in_valid = dec_valid && s_ff.src.if_enable;
      end
   end
   assign pop         = cpu_valid && skid_ready && (s_ff.rep_cnt == rep_max);
   assign dec_request = s_ff.src.dec_fetch_en && !s_ff.src.src_cpu && skid_ready
                        && s_ff.src.if_enable;
   assign audio_irq   = irq_global_en && s_ff.src.src_cpu
                        && ((s_ff.sample_request_flag && !s_ff.src.sample_request_flag_mask)
                        || (s_ff.underrun_flag && !s_ff.src.underrun_flag_mask));

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s = s_ff;
      if (sfr.wr) begin
         case (sfr.addr)
            `AO_OFS_FORMAT:  nxt_s.fmt = audio_out_pkg::format_t'(sfr.wdata);
            `AO_OFS_SOURCE:  nxt_s.src = audio_out_pkg::source_t'(sfr.wdata & `AO_SRC_WMASK);
            `AO_OFS_SAMPLE:  nxt_s.sample = sfr.wdata;
            `AO_OFS_DIVISOR: nxt_s.div = sfr.wdata[4:0] & 5'(`AO_DIV_WMASK);
            default: ;
         endcase
      end
      if (sfr.rd) begin
         case (sfr.addr)
            `AO_OFS_FORMAT:  nxt_s.rdata = s_ff.fmt;
            `AO_OFS_SOURCE:  nxt_s.rdata = s_ff.src;
            `AO_OFS_STATUS:  nxt_s.rdata = status;
            `AO_OFS_SAMPLE:  nxt_s.rdata = s_ff.sample;
            `AO_OFS_DIVISOR: nxt_s.rdata = {3'h0, s_ff.div};
            default:         nxt_s.rdata = 8'h00;
         endcase
      end
      if (wr_sample) begin
         nxt_s.wr_ptr = s_ff.wr_ptr + 3'h1;
      end
      if (cpu_valid && skid_ready) begin
         nxt_s.rep_cnt = pop ? 3'h0 : s_ff.rep_cnt + 3'h1;
      end
      if (pop) begin
         nxt_s.rd_ptr = s_ff.rd_ptr + 3'h1;
      end
      nxt_s.count = s_ff.count + {3'h0, wr_sample} - {3'h0, pop};
      // A write beside a pop keeps the count, so no set event can meet it
      if (wr_sample) begin
         nxt_s.sample_request_flag = 1'b0;
         nxt_s.underrun_flag = 1'b0;
      end
      if (pop && s_ff.count == `AO_BUF_HALF && !wr_sample) begin
         nxt_s.sample_request_flag = 1'b1;
      end
      if (pop && s_ff.count == 4'h1 && !wr_sample) begin
         nxt_s.underrun_flag = 1'b1;
      end
      // Two-entry skid buffer ahead of the serializer
      case (s_ff.skid_n)
         2'h0: begin
            if (in_valid) begin
               nxt_s.skid0  = in_word;
               nxt_s.skid_n = 2'h1;
            end
         end
         2'h1: begin
            if (ser_ready && in_valid) begin
               nxt_s.skid0 = in_word;
            end else if (ser_ready) begin
               nxt_s.skid_n = 2'h0;
            end else if (in_valid) begin
               nxt_s.skid1  = in_word;
               nxt_s.skid_n = 2'h2;
            end
         end
         default: begin
            if (ser_ready) begin
               nxt_s.skid0  = s_ff.skid1;
               nxt_s.skid_n = 2'h1;
            end
         end
      endcase
      case (s_ff.play)
         audio_out_pkg::ST_OFF: begin
            if (s_ff.src.if_enable) begin
               nxt_s.play = audio_out_pkg::ST_RUN;
            end
         end
         default: begin
            if (!s_ff.src.if_enable) begin
               nxt_s.play   = audio_out_pkg::ST_OFF;
               nxt_s.skid_n = 2'h0;
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_ff         <= '0;
         s_ff.fmt     <= audio_out_pkg::format_t'(`AO_RST_FORMAT);
         s_ff.src     <= audio_out_pkg::source_t'(`AO_RST_SOURCE);
         s_ff.sample  <= `AO_RST_SAMPLE;
         s_ff.div     <= 5'(`AO_RST_DIVISOR);
         s_ff.sample_request_flag    <= 1'b1;
         s_ff.underrun_flag    <= 1'b1;
         s_ff.play    <= audio_out_pkg::ST_OFF;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Sample storage, written by index
   always_ff @(posedge clock) begin
      if (wr_sample) begin
         mem_ff[s_ff.wr_ptr] <= sfr.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign sfr_rdata   = s_ff.rdata;
   assign ser_data    = s_ff.skid0;
   assign ser_valid   = (s_ff.skid_n != 2'h0);
   assign ser_format  = s_ff.fmt;
   assign if_enabled  = (s_ff.play == audio_out_pkg::ST_RUN);
   assign clk_divisor = s_ff.div;

   ////////////////////////////////////////////////////////////////////////////
   a_sample_request_flag_sets: assert property (@(posedge clock) disable iff (rst)
      (pop && s_ff.count == 4'h4 && !wr_sample) |=> s_ff.sample_request_flag)
      else $error("sample request flag not set at four to three");
   a_underrun_flag_sets: assert property (@(posedge clock) disable iff (rst)
      (pop && s_ff.count == 4'h1 && !wr_sample) |=> (s_ff.underrun_flag && s_ff.count == 4'h0))
      else $error("underrun flag not set on empty");
   a_write_clears: assert property (@(posedge clock) disable iff (rst)
      wr_sample |=> (!s_ff.sample_request_flag && !s_ff.underrun_flag))
      else $error("sample write did not clear flags");
   a_busy_full: assert property (@(posedge clock) disable iff (rst)
      (wr_sample && !pop && s_ff.count == 4'h7) |=> status[5])
      else $error("busy flag not set when buffer filled");
   a_irq_masked: assert property (@(posedge clock) disable iff (rst)
      (s_ff.src.sample_request_flag_mask && s_ff.src.underrun_flag_mask) |-> !audio_irq)
      else $error("interrupt raised while both sources masked");
   a_irq_global: assert property (@(posedge clock) disable iff (rst)
      !irq_global_en |-> !audio_irq)
      else $error("interrupt raised without global enable");
   a_underrun_flag_irq: assert property (@(posedge clock) disable iff (rst)
      (irq_global_en && s_ff.src.src_cpu && s_ff.underrun_flag && !s_ff.src.underrun_flag_mask) |-> audio_irq)
      else $error("unmasked underrun gave no interrupt");
   a_resv_zero: assert property (@(posedge clock) disable iff (rst)
      (sfr.rd && sfr.addr == 8'h9b) |=> !sfr_rdata[3])
      else $error("reserved source bit read as one");
   a_status_ro: assert property (@(posedge clock) disable iff (rst)
      (sfr.wr && sfr.addr == 8'h9c && !pop) |=> $stable(s_ff.sample_request_flag))
      else $error("status write changed a flag");
   a_dec_stop: assert property (@(posedge clock) disable iff (rst)
      !s_ff.src.dec_fetch_en |-> !dec_request)
      else $error("decoder request while fetch disabled");
   a_req_enable: assert property (@(posedge clock) disable iff (rst)
      !s_ff.src.if_enable |-> !dec_request)
      else $error("decoder request while interface disabled");
   a_dec_cpu: assert property (@(posedge clock) disable iff (rst)
      s_ff.src.src_cpu |-> !dec_request)
      else $error("decoder request while CPU source selected");
   a_ena_off: assert property (@(posedge clock) disable iff (rst)
      !s_ff.src.if_enable |=> !if_enabled)
      else $error("interface still running after disable");
   a_ena_on: assert property (@(posedge clock) disable iff (rst)
      s_ff.src.if_enable |=> if_enabled)
      else $error("interface not running after enable");
   a_ser_hold: assert property (@(posedge clock) disable iff (rst)
      (ser_valid && !ser_ready && s_ff.src.if_enable) |=> (ser_valid && $stable(ser_data)))
      else $error("serializer word dropped or changed while stalled");

   // Flags, interrupt, fill level and pointers
   a_busy_clears: assert property (@(posedge clock) disable iff (rst)
      (status[5] && pop) |=> !status[5])
      else $error("busy flag kept after buffer left full");
   a_full_refuse: assert property (@(posedge clock) disable iff (rst)
      (sfr.wr && sfr.addr == 8'h9d && status[5] && !pop) |=> status[5])
      else $error("write into full buffer changed fill level");
   a_count_bound: assert property (@(posedge clock) disable iff (rst)
      s_ff.count <= 4'h8)
      else $error("fill level beyond buffer depth");
   a_push_count: assert property (@(posedge clock) disable iff (rst)
      (wr_sample && !pop) |=> s_ff.count == $past(s_ff.count) + 4'h1)
      else $error("sample write did not raise fill level");
   a_ptr_push: assert property (@(posedge clock) disable iff (rst)
      wr_sample |=> s_ff.wr_ptr == $past(s_ff.wr_ptr) + 3'h1)
      else $error("write pointer did not advance");
   a_ptr_pop: assert property (@(posedge clock) disable iff (rst)
      pop |=> s_ff.rd_ptr == $past(s_ff.rd_ptr) + 3'h1)
      else $error("read pointer did not advance");
   a_sample_request_flag_sticky: assert property (@(posedge clock) disable iff (rst)
      (s_ff.sample_request_flag && !wr_sample) |=> s_ff.sample_request_flag)
      else $error("sample request flag cleared without a write");
   a_underrun_flag_sticky: assert property (@(posedge clock) disable iff (rst)
      (s_ff.underrun_flag && !wr_sample) |=> s_ff.underrun_flag)
      else $error("underrun flag cleared without a write");
   a_irq_sample_request_flag: assert property (@(posedge clock) disable iff (rst)
      (irq_global_en && s_ff.src.src_cpu && s_ff.sample_request_flag && !s_ff.src.sample_request_flag_mask) |-> audio_irq)
      else $error("unmasked sample request gave no interrupt");
   a_irq_source: assert property (@(posedge clock) disable iff (rst)
      !s_ff.src.src_cpu |-> !audio_irq)
      else $error("interrupt raised in decoder mode");
   a_irq_flagless: assert property (@(posedge clock) disable iff (rst)
      (!s_ff.sample_request_flag && !s_ff.underrun_flag) |-> !audio_irq)
      else $error("interrupt raised with no flag set");

   // Register writes and read padding
   a_sample_write: assert property (@(posedge clock) disable iff (rst)
      (sfr.wr && sfr.addr == 8'h9d) |=> s_ff.sample == $past(sfr.wdata))
      else $error("sample register did not take written byte");
   a_status_pad: assert property (@(posedge clock) disable iff (rst)
      (sfr.rd && sfr.addr == 8'h9c) |=> sfr_rdata[4:0] == 5'h00)
      else $error("reserved status bits read as one");
   a_div_pad: assert property (@(posedge clock) disable iff (rst)
      (sfr.rd && sfr.addr == 8'hec) |=> sfr_rdata[7:5] == 3'h0)
      else $error("reserved divisor bits read as one");
   a_div_write: assert property (@(posedge clock) disable iff (rst)
      (sfr.wr && sfr.addr == 8'hec) |=> clk_divisor == $past(sfr.wdata[4:0]))
      else $error("divisor write not on the port");
   a_fmt_write: assert property (@(posedge clock) disable iff (rst)
      (sfr.wr && sfr.addr == 8'h9a) |=> ser_format == audio_out_pkg::format_t'($past(sfr.wdata)))
      else $error("format write not on the port");
   a_src_write: assert property (@(posedge clock) disable iff (rst)
      (sfr.wr && sfr.addr == 8'h9b)
      |=> s_ff.src == audio_out_pkg::source_t'($past(sfr.wdata) & 8'hf7))
      else $error("source write not taken at its edge");
endmodule : audio_out_ctrl
`default_nettype wire

// *** dv/audio_out_sink.sv ***
// Serializer-side partner: takes words with random stalls.
// Assumes the block's clock and reset.
`timescale 1ns/1ns
`default_nettype none
module audio_out_sink (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [15:0] ser_data,
   input  wire logic        ser_valid,
   output logic             ser_ready,
   input  wire logic        stall
);
   logic [15:0] got [$];
   // Random ready so the skid path sees quick and slow answers
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ser_ready <= 1'b0;
      end else begin
         if (ser_valid && ser_ready) got.push_back(ser_data);
         ser_ready <= !stall && ($urandom_range(3) != 0);
      end
   end
endmodule : audio_out_sink
`default_nettype wire

// *** dv/audio_output_interface_ctrl_test.sv ***
// Self-checking bench of the audio output control block.
// Assumes the package and audio_out_sink are compiled first.
`timescale 1ns/1ns
`default_nettype none
module audio_output_interface_ctrl_test;
   logic                    clock = 1'b0;
   logic                    rst = 1'b1;
   audio_out_pkg::sfr_req_t sfr = '0;
   logic                    irq_global_en = 1'b0;
   logic [15:0]             dec_data = 16'h0000;
   logic                    dec_valid = 1'b0;
   logic                    stall = 1'b1;
   logic [7:0]              sfr_rdata, v, st;
   logic                    audio_irq, dec_request, ser_valid, ser_ready, if_enabled;
   logic [15:0]             ser_data, w;
   audio_out_pkg::format_t  ser_format;
   logic [4:0]              clk_divisor;
   logic [15:0]             exp_q [$];
   int                      miscompares = 0, num_checks = 0, cycles = 0, n;

   audio_out_ctrl dut (.clock(clock), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
      .irq_global_en(irq_global_en), .audio_irq(audio_irq), .dec_data(dec_data),
      .dec_valid(dec_valid), .dec_request(dec_request), .ser_data(ser_data),
      .ser_valid(ser_valid), .ser_ready(ser_ready), .ser_format(ser_format),
      .if_enabled(if_enabled), .clk_divisor(clk_divisor));
   audio_out_sink sink (.clock(clock), .rst(rst), .ser_data(ser_data),
      .ser_valid(ser_valid), .ser_ready(ser_ready), .stall(stall));

   always #50 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles > 40000) begin
         miscompares++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
      num_checks++;
      if (got !== want) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) sfr <= {a, d, 2'b10};
      @(posedge clock) sfr <= {a, d, 2'b00};
   endtask : wr
   task automatic sfr_read(input logic [7:0] a);
      @(posedge clock) sfr <= {a, 8'h00, 2'b01};
      @(posedge clock) sfr <= {a, 8'h00, 2'b00};
      @(negedge clock) st = sfr_rdata;
   endtask : sfr_read
   task automatic rchk(input logic [7:0] a, input logic [7:0] want, input string what);
      sfr_read(a);
      chk(st, want, what);
   endtask : rchk
   function automatic int fac(input int r);
      return (r == 3) ? 6 : (1 << r);
   endfunction : fac
   // Extra idle cycles catch surplus words, not only missing ones
   task automatic drain(input string what);
      @(posedge clock) stall <= 1'b0;
      for (n = 0; n < 2000 && sink.got.size() < exp_q.size(); n++) @(posedge clock);
      repeat (8) @(posedge clock);
      chk(16'(sink.got.size()), 16'(exp_q.size()), what);
      foreach (exp_q[i]) if (i < sink.got.size()) chk(sink.got[i], exp_q[i], what);
      sink.got.delete();
      exp_q.delete();
   endtask : drain
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n = $urandom(26);
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rchk(8'h9a, 8'h08, "format reset");
      rchk(8'h9b, 8'hb2, "source reset");
      rchk(8'h9c, 8'hc0, "status reset");
      rchk(8'h9d, 8'hff, "sample reset");
      rchk(8'hec, 8'h00, "divisor reset");
      rchk(8'h55, 8'h00, "unmapped read");
      wr(8'h9c, 8'h3f);
      rchk(8'h9c, 8'hc0, "status write");
      wr(8'hec, 8'hff);
      rchk(8'hec, 8'h1f, "divisor bits");
      chk(clk_divisor, 5'h1f, "divisor port");
      for (int i = 0; i < 4; i++) begin
         v = (i == 3) ? 8'($urandom) : (i == 0) ? 8'h04 : (i == 1) ? 8'h83 : 8'h08;
         wr(8'h9a, v);
         rchk(8'h9a, v, "format readback");
         chk(ser_format, v, "format port");
      end
      @(posedge clock) irq_global_en <= 1'b1;
      // Voice path per repeat code: fill while stalled, refuse when full, drain
      for (int r = 0; r < 4; r++) begin
         @(posedge clock) stall <= 1'b1;
         wr(8'h9b, 8'(8'h81 | (r << 1)));
         rchk(8'h9b, 8'(8'h81 | (r << 1)), "source readback");
         chk(if_enabled, 1'b1, "enabled");
         for (int k = 0; k < 16; k++) begin
            sfr_read(8'h9c);
            chk(st[4:0], 5'h00, "status reserved");
            if (st[5]) break;
            v = 8'($urandom);
            wr(8'h9d, v);
            for (int j = 0; j < fac(r); j++) exp_q.push_back({v, 8'h00});
         end
         chk(st, 8'h20, "busy when full");
         wr(8'h9d, 8'h5a);
         drain("voice stream");
         rchk(8'h9c, 8'hc0, "drained flags");
         chk(audio_irq, 1'b1, "irq unmasked");
      end
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 8'ha1 : (i == 1) ? 8'hb1 : 8'h91;
         wr(8'h9b, v);
         @(negedge clock) chk(audio_irq, !(v[5] && v[4]), "irq mask");
      end
      @(posedge clock) irq_global_en <= 1'b0;
      @(negedge clock) chk(audio_irq, 1'b0, "global off");
      wr(8'h9b, 8'h80);
      @(posedge clock);
      @(negedge clock) chk(if_enabled, 1'b0, "disabled");
      wr(8'h9b, 8'h71);
      @(negedge clock) chk(dec_request, 1'b1, "fetch on");
      for (int k = 0; k < 12; k++) begin
         for (n = 0; n < 200 && dec_request !== 1'b1; n++) @(negedge clock);
         w = 16'($urandom);
         @(posedge clock) dec_valid <= 1'b1;
         dec_data <= w;
         exp_q.push_back(w);
         @(posedge clock) dec_valid <= 1'b0;
         @(negedge clock);
      end
      wr(8'h9b, 8'h31);
      @(negedge clock) chk(dec_request, 1'b0, "fetch off");
      drain("decoder stream");
      summarize();
   end
endmodule : audio_output_interface_ctrl_test
`default_nettype wire
